/* hw/pef_event_flags.v */
// Four 8-bit per-port event registers with plain and clear-on-read command codes,
// summary bits and the active-low interrupt pin. Assumes a command decoder that
// presents one read strobe with its command code, and event pulses from port logic.
`timescale 1ns/1ns
`default_nettype none
`include "pef_regs.vh"

// Notes on behaviour
// - Power change register: view and clear codes
// - Sense register: view and clear codes
// - Fault register: view and clear codes
// - Start/limit register: view and clear codes
// - Clear-on-read releases interrupt it caused
// - Flags active high, feed summary bits
// - Ports one to four ascend per nibble
// - Power: high good change, low enable
// - Port off clears sense, fault, limit flags
// - Class flag each cycle or on change
// - Sense flag each cycle or on change
// - Fault: high unplug, low overload timer
// - Cut-off disabled: flag at half limit time
// - Cut-off disabled: clear resets overload counter
// - Clear leaves limit duration counter alone
// - Cut-off enabled: normal timer, no reset
// - Limit flag after limit time exceeded
// - Start flag on start or enable errors
// - All flags reset zero, host read-only
// - Pin needs summary, mask and enable
// - Summary bits cleared by read or reset
// - Undervoltage shut-off sets change flags
module pef_event_flags #(
  parameter NPORT = 4,
  parameter LIMIT_CYCLES = `PEF_LIMIT_TIME_MS * 1000 * `PEF_CLK_MHZ
) (
  input wire sys_clk,
  input wire resetn,
  input wire rd_strobe,
  input wire [7:0] rd_cmd,
  output reg [7:0] rd_data,
  output reg rd_valid,
  input wire [7:0] irq_mask,
  input wire global_irq_enable,
  input wire clear_all_summary,
  input wire class_change_only,
  input wire sense_change_only,
  input wire [NPORT-1:0] overload_cut_enable,
  input wire [NPORT-1:0] port_on,
  input wire [NPORT-1:0] power_good,
  input wire [NPORT-1:0] class_done,
  input wire [NPORT*3-1:0] class_result,
  input wire [NPORT-1:0] sense_done,
  input wire [NPORT*4-1:0] sense_result,
  input wire [NPORT-1:0] unplug_event,
  input wire [NPORT-1:0] overload,
  input wire [NPORT-1:0] overload_time_out,
  input wire [NPORT-1:0] at_limit,
  input wire [NPORT-1:0] start_fault,
  input wire [NPORT-1:0] enable_turn_on_error,
  output reg [7:0] summary,
  output reg irq_n
);
  // ****************************************
  // Command decode
  // ****************************************
  wire clr_pwr = rd_strobe && rd_cmd == `PEF_CMD_PWR_CLR;
  wire clr_sns = rd_strobe && rd_cmd == `PEF_CMD_SNS_CLR;
  wire clr_flt = rd_strobe && rd_cmd == `PEF_CMD_FLT_CLR;
  wire clr_stl = rd_strobe && rd_cmd == `PEF_CMD_STL_CLR;
  wire hit_pwr = rd_strobe && (rd_cmd == `PEF_CMD_PWR_VIEW || clr_pwr);
  wire hit_sns = rd_strobe && (rd_cmd == `PEF_CMD_SNS_VIEW || clr_sns);
  wire hit_flt = rd_strobe && (rd_cmd == `PEF_CMD_FLT_VIEW || clr_flt);
  wire hit_stl = rd_strobe && (rd_cmd == `PEF_CMD_STL_VIEW || clr_stl);

  reg [NPORT-1:0] good_state_changed, enable_state_changed;
  reg [NPORT-1:0] class_cycle_flag, sense_cycle_flag;
  reg [NPORT-1:0] unplug_flag, overload_cut_flag;
  reg [NPORT-1:0] current_limited_flag, turn_on_fault_flag;
  reg [NPORT-1:0] prev_on, prev_good;
  wire [NPORT-1:0] set_class, set_sense, set_cut, set_lim;

  // Port n at bit n of each nibble
  wire [7:0] pwr_reg = {good_state_changed, enable_state_changed};
  wire [7:0] sns_reg = {class_cycle_flag, sense_cycle_flag};
  wire [7:0] flt_reg = {unplug_flag, overload_cut_flag};
  wire [7:0] stl_reg = {current_limited_flag, turn_on_fault_flag};

  // ****************************************
  // Per-port event sources
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1) begin : g_port
      reg [2:0] last_class;
      reg [3:0] last_sense;
      reg [31:0] lim_cnt;
      reg [31:0] cut_cnt;
      wire [2:0] cls = class_result[p*3 +: 3];
      wire [3:0] sns = sense_result[p*4 +: 4];
      assign set_class[p] = class_done[p] && (!class_change_only || cls != last_class);
      assign set_sense[p] = sense_done[p] && (!sense_change_only || sns != last_sense);
      assign set_lim[p] = at_limit[p] && lim_cnt == LIMIT_CYCLES;
      // Without cut-off the overload timer runs at half the limit time
      assign set_cut[p] = overload_cut_enable[p] ? overload_time_out[p] :
                          (overload[p] && cut_cnt == LIMIT_CYCLES / 2);
      always @(posedge sys_clk) begin
        if (!resetn || !port_on[p]) begin
          last_class <= 3'h0;
          last_sense <= 4'h0;
        end else begin
          if (class_done[p])
            last_class <= cls;
          if (sense_done[p])
            last_sense <= sns;
        end
        // Limit duration counter is never touched by a clear-on-read
        if (!resetn || !at_limit[p])
          lim_cnt <= 32'h0;
        else if (lim_cnt != LIMIT_CYCLES)
          lim_cnt <= lim_cnt + 32'h1;
        if (!resetn || !overload[p] || overload_cut_enable[p])
          cut_cnt <= 32'h0;
        else if (clr_flt)
          cut_cnt <= 32'h0;
        else if (cut_cnt <= LIMIT_CYCLES / 2)
          cut_cnt <= cut_cnt + 32'h1;
      end
    end
  endgenerate

  // ****************************************
  // Event registers
  // ****************************************
  // Set wins over clear so no event is lost
  always @(posedge sys_clk) begin
    if (!resetn) begin
      good_state_changed <= {NPORT{1'b0}};
      enable_state_changed <= {NPORT{1'b0}};
      class_cycle_flag <= {NPORT{1'b0}};
      sense_cycle_flag <= {NPORT{1'b0}};
      unplug_flag <= {NPORT{1'b0}};
      overload_cut_flag <= {NPORT{1'b0}};
      current_limited_flag <= {NPORT{1'b0}};
      turn_on_fault_flag <= {NPORT{1'b0}};
      prev_on <= {NPORT{1'b0}};
      prev_good <= {NPORT{1'b0}};
    end else begin
      prev_on <= port_on;
      prev_good <= power_good;
      // Any cause of a state change, undervoltage shut-off included
      good_state_changed <= (clr_pwr ? {NPORT{1'b0}} : good_state_changed)
        | (power_good ^ prev_good);
      enable_state_changed <= (clr_pwr ? {NPORT{1'b0}} : enable_state_changed)
        | (port_on ^ prev_on);
      class_cycle_flag <= ((clr_sns ? {NPORT{1'b0}} : class_cycle_flag)
        | set_class) & port_on;
      sense_cycle_flag <= ((clr_sns ? {NPORT{1'b0}} : sense_cycle_flag)
        | set_sense) & port_on;
      unplug_flag <= ((clr_flt ? {NPORT{1'b0}} : unplug_flag)
        | unplug_event) & port_on;
      overload_cut_flag <= ((clr_flt ? {NPORT{1'b0}} : overload_cut_flag)
        | set_cut) & port_on;
      current_limited_flag <= ((clr_stl ? {NPORT{1'b0}} : current_limited_flag)
        | set_lim) & port_on;
      // Start faults are raised as the port drops, so they are not masked by it
      turn_on_fault_flag <= (clr_stl ? {NPORT{1'b0}} : turn_on_fault_flag)
        | start_fault | enable_turn_on_error;
    end
  end

  // ****************************************
  // Read path, summary and interrupt pin
  // ****************************************
  reg [7:0] next_summary;
  always @* begin
    next_summary = clear_all_summary ? 8'h00 : summary;
    if (clr_pwr || hit_pwr) begin
      next_summary[`PEF_SUM_GOOD] = 1'b0;
      next_summary[`PEF_SUM_EN] = 1'b0;
    end
    if (hit_sns) begin
      next_summary[`PEF_SUM_SENSE] = 1'b0;
      next_summary[`PEF_SUM_CLASS] = 1'b0;
    end
    if (hit_flt) begin
      next_summary[`PEF_SUM_UNPLUG] = 1'b0;
      next_summary[`PEF_SUM_IFLT] = 1'b0;
    end
    if (hit_stl) begin
      next_summary[`PEF_SUM_START] = 1'b0;
      next_summary[`PEF_SUM_IFLT] = 1'b0;
    end
    // New set flags raise summary bits again, winning over a clear
    if (|(power_good ^ prev_good)) next_summary[`PEF_SUM_GOOD] = 1'b1;
    if (|(port_on ^ prev_on)) next_summary[`PEF_SUM_EN] = 1'b1;
    if (|set_sense) next_summary[`PEF_SUM_SENSE] = 1'b1;
    if (|set_class) next_summary[`PEF_SUM_CLASS] = 1'b1;
    if (|unplug_event) next_summary[`PEF_SUM_UNPLUG] = 1'b1;
    if (|(set_cut | set_lim)) next_summary[`PEF_SUM_IFLT] = 1'b1;
    if (|(start_fault | enable_turn_on_error)) next_summary[`PEF_SUM_START] = 1'b1;
    next_summary[7] = 1'b0;
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      rd_data <= `PEF_EVT_RESET;
      rd_valid <= 1'b0;
      summary <= 8'h00;
      irq_n <= 1'b1;
    end else begin
      rd_valid <= hit_pwr | hit_sns | hit_flt | hit_stl;
      // Both codes return the byte as it stood before the clear
      rd_data <= hit_pwr ? pwr_reg : hit_sns ? sns_reg : hit_flt ? flt_reg :
                 hit_stl ? stl_reg : 8'h00;
      summary <= next_summary;
      irq_n <= !(global_irq_enable && |(next_summary & irq_mask));
    end
  end
endmodule // pef_event_flags
`default_nettype wire

/* hw/pef_regs.vh */
// Command codes, field positions, reset values and timing for the port event flag bank.
// Assumes inclusion by the event flag module only.
`ifndef PEF_REGS_VH
`define PEF_REGS_VH
// ****************************************
// Command codes
// ****************************************
`define PEF_CMD_PWR_VIEW 8'h02
`define PEF_CMD_PWR_CLR 8'h03
`define PEF_CMD_SNS_VIEW 8'h04
`define PEF_CMD_SNS_CLR 8'h05
`define PEF_CMD_FLT_VIEW 8'h06
`define PEF_CMD_FLT_CLR 8'h07
`define PEF_CMD_STL_VIEW 8'h08
`define PEF_CMD_STL_CLR 8'h09
// ****************************************
// Field positions and reset values
// ****************************************
`define PEF_HI_NIB 4
`define PEF_LO_NIB 0
`define PEF_EVT_RESET 8'h00
`define PEF_SUM_GOOD 1
`define PEF_SUM_EN 0
`define PEF_SUM_UNPLUG 2
`define PEF_SUM_SENSE 3
`define PEF_SUM_CLASS 4
`define PEF_SUM_IFLT 5
`define PEF_SUM_START 6
// ****************************************
// Timing
// ****************************************
`define PEF_LIMIT_TIME_MS 60
`define PEF_CLK_MHZ 100
`endif

/* test/pef_event_flags_checker.sv */
// Port-level checker for the port event flag bank.
// Assumes it is bound into pef_event_flags and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module pef_event_flags_checker #(
  parameter NPORT = 4
) (
  input wire sys_clk,
  input wire resetn,
  input wire rd_strobe,
  input wire [7:0] rd_cmd,
  input wire rd_valid,
  input wire [7:0] irq_mask,
  input wire global_irq_enable,
  input wire [NPORT-1:0] port_on,
  input wire [NPORT-1:0] unplug_event,
  input wire [7:0] summary,
  input wire irq_n
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire mapped = rd_cmd >= 8'h02 && rd_cmd <= 8'h09;
  sequence s_cause;
    (|(summary & irq_mask)) && global_irq_enable;
  endsequence
  sequence s_idle;
    (summary & irq_mask) == 8'h00;
  endsequence
  property p_answer; rd_strobe && mapped |=> rd_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer to read");
  property p_unmapped; rd_strobe && !mapped |=> !rd_valid; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped code answered");
  property p_quiet; !rd_strobe |=> !rd_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without read");
  property p_top_zero; summary[7] == 1'b0; endproperty
  a_top_zero: assert property (p_top_zero) else $error("summary bit 7 set");
  property p_unplug; unplug_event[0] && port_on[0] |=> summary[2]; endproperty
  a_unplug: assert property (p_unplug) else $error("unplug summary missing");
  property p_no_enable; !global_irq_enable |=> irq_n; endproperty
  a_no_enable: assert property (p_no_enable) else $error("irq while disabled");
  property p_irq_low; s_cause ##1 s_cause |-> !irq_n; endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq not raised");
  property p_release; s_idle ##1 s_idle |-> irq_n; endproperty
  a_release: assert property (p_release) else $error("irq not released");
endmodule // pef_event_flags_checker
bind pef_event_flags pef_event_flags_checker #(.NPORT(NPORT)) u_chk (.sys_clk, .resetn,
  .rd_strobe, .rd_cmd, .rd_valid, .irq_mask, .global_irq_enable, .port_on, .unplug_event,
  .summary, .irq_n);
`default_nettype wire

/* test/pef_event_flags_tb_top.sv */
// Self-checking bench for the port event flag bank.
// Assumes the host model drives reads and the bench drives port events.
`timescale 1ns/1ns
`default_nettype none
module pef_event_flags_tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] irq_mask = 8'h04;
  logic global_irq_enable = 1'b1;
  logic clear_all_summary = 1'b0;
  logic [3:0] port_on = 4'h0, power_good = 4'h0, class_done = 4'h0, sense_done = 4'h0;
  logic [3:0] unplug_event = 4'h0, at_limit = 4'h0, start_fault = 4'h0;
  logic class_change_only = 1'b0, sense_change_only = 1'b0;
  logic [3:0] overload_cut_enable = 4'hf, overload = 4'h0, enable_turn_on_error = 4'h0;
  logic [7:0] got;
  logic vld;
  wire [7:0] rd_data, rd_cmd, summary;
  wire rd_valid, rd_strobe, irq_n;
  int n_mismatch = 0, checked = 0;
  logic [15:0] rows [13] = '{16'h022f, 16'h032f, 16'h0200, 16'h0484, 16'h0584, 16'h0400,
    16'h0610, 16'h0710, 16'h0600, 16'h0802, 16'h0902, 16'h0800, 16'h0a00};
  // Short limit time keeps the run brief
  pef_event_flags #(.LIMIT_CYCLES(20)) dut (.sys_clk, .resetn, .rd_strobe, .rd_cmd, .rd_data,
    .rd_valid, .irq_mask, .global_irq_enable, .clear_all_summary, .class_change_only,
    .sense_change_only, .overload_cut_enable, .port_on, .power_good, .class_done,
    .class_result(12'h000), .sense_done, .sense_result(16'h0000), .unplug_event,
    .overload, .overload_time_out(4'h0), .at_limit, .start_fault,
    .enable_turn_on_error, .summary, .irq_n);
  pef_host_model host (.sys_clk, .rd_data, .rd_valid, .rd_strobe, .rd_cmd);
  always #5 sys_clk = ~sys_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 12; i++) begin
      host.read_cmd(rows[i][15:8], got, vld);
      check(got, 8'h00);
    end
    port_on = 4'hf;
    power_good = 4'h2;
    @(posedge sys_clk);
    #1;
    {sense_done, class_done, unplug_event, start_fault} = 16'h4812;
    @(posedge sys_clk);
    #1;
    {sense_done, class_done, unplug_event, start_fault} = 16'h0000;
    @(posedge sys_clk);
    #1;
    check({7'h00, irq_n}, 8'h00);
    for (int i = 0; i < 13; i++) begin
      host.read_cmd(rows[i][15:8], got, vld);
      check(got, rows[i][7:0]);
      check({7'h00, vld}, {7'h00, rows[i][15:8] inside {[8'h02:8'h09]}});
    end
    // Event pulse pulls the pin low, clear-on-read releases it high again
    unplug_event = 4'h8;
    @(posedge sys_clk);
    #1;
    unplug_event = 4'h4;
    @(posedge sys_clk);
    #1;
    unplug_event = 4'h0;
    check({7'h00, irq_n}, 8'h00);
    port_on[2] = 1'b0;
    host.read_cmd(8'h07, got, vld);
    check(got, 8'h80);
    check({7'h00, irq_n}, 8'h01);
    at_limit = 4'h1;
    repeat (23) @(posedge sys_clk);
    #1;
    at_limit = 4'h0;
    host.read_cmd(8'h08, got, vld);
    check(got, 8'h10);
    // Cut-off off on port 0: flag at half the limit time, clear restarts the count
    overload_cut_enable = 4'he;
    overload = 4'h1;
    repeat (12) @(posedge sys_clk);
    #1;
    host.read_cmd(8'h07, got, vld);
    check(got, 8'h01);
    repeat (12) @(posedge sys_clk);
    #1;
    host.read_cmd(8'h06, got, vld);
    check(got, 8'h01);
    overload = 4'h0;
    host.read_cmd(8'h07, got, vld);
    check(got, 8'h01);
    // Unchanged results raise nothing while change-only is set
    class_change_only = 1'b1;
    sense_change_only = 1'b1;
    {sense_done, class_done} = 8'h11;
    @(posedge sys_clk);
    #1;
    {sense_done, class_done} = 8'h00;
    host.read_cmd(8'h05, got, vld);
    check(got, 8'h00);
    enable_turn_on_error = 4'h8;
    @(posedge sys_clk);
    #1;
    enable_turn_on_error = 4'h0;
    host.read_cmd(8'h09, got, vld);
    check(got, 8'h18);
    // Pin stays high while the global enable is off
    global_irq_enable = 1'b0;
    unplug_event = 4'h1;
    @(posedge sys_clk);
    #1;
    unplug_event = 4'h0;
    global_irq_enable = 1'b1;
    check({7'h00, irq_n}, 8'h01);
    @(posedge sys_clk);
    #1;
    check({7'h00, irq_n}, 8'h00);
    clear_all_summary = 1'b1;
    @(posedge sys_clk);
    #1;
    clear_all_summary = 1'b0;
    check(summary, 8'h00);
    finish_test();
  end
endmodule // pef_event_flags_tb_top
`default_nettype wire

/* test/pef_host_model.sv */
// Host model: issues one-byte reads at command codes.
// Assumes the bank answers one cycle after the strobe edge.
`timescale 1ns/1ns
`default_nettype none
module pef_host_model (
  input wire sys_clk,
  input wire [7:0] rd_data,
  input wire rd_valid,
  output logic rd_strobe,
  output logic [7:0] rd_cmd
);
  initial begin
    rd_strobe = 1'b0;
    rd_cmd = 8'h00;
  end
  task automatic read_cmd(input logic [7:0] cmd, output logic [7:0] data, output logic valid);
    @(posedge sys_clk);
    #1;
    rd_strobe = 1'b1;
    rd_cmd = cmd;
    @(posedge sys_clk);
    #1;
    rd_strobe = 1'b0;
    rd_cmd = ~cmd;
    data = rd_data;
    valid = rd_valid;
  endtask
endmodule // pef_host_model
`default_nettype wire
